// File: eepc_pkg.sv
// Constants and types of the EEPROM program and erase controller
// What this block does
// RQ1: 512-byte array mapped at 0800 to 09FF
// RQ2: Reset copies nonvolatile config and divider values
// RQ3: Timebase divides crystal or bus clock
// RQ4: Software loads divider with rounded reference count
// RQ5: Security freezes bytes 08F0 to 08FF
// RQ6: Security freezes the nonvolatile config byte
// RQ7: Security refuses block and bulk erase
// RQ8: Four 128-byte blocks, each with protect bit
// RQ9: Block protect refreshes on reset or read
// RQ10: Divider lock zero freezes divider values
// RQ11: Program only clears bits, erased reads FF
// RQ12: Erase sets bytes, byte up to array
// RQ13: Software never reprograms a zero bit
// RQ14: Self-timed mode ends cycle, clears enable
// RQ15: Program only unprotected bytes, config byte or divider bytes
// RQ16: Enable needs latch mode and latched address
// RQ17: Latch mode captures last valid address, data
// RQ18: Clearing enable and latch clears enable only
// RQ19: Divider counts references, ticks, restarts
package eepc_pkg;
  localparam logic [15:0] ARR_LO      = 16'h0800;
  localparam logic [15:0] ARR_HI      = 16'h09ff;
  localparam logic [15:0] A_DIVNV_HI  = 16'hfe10;
  localparam logic [15:0] A_DIVNV_LO  = 16'hfe11;
  localparam logic [15:0] A_IRQ_STAT  = 16'hfe12;
  localparam logic [15:0] A_IRQ_MASK  = 16'hfe13;
  localparam logic [15:0] A_DIV_HI    = 16'hfe1a;
  localparam logic [15:0] A_DIV_LO    = 16'hfe1b;
  localparam logic [15:0] A_CFGNV     = 16'hfe1c;
  localparam logic [15:0] A_CTRL      = 16'hfe1d;
  localparam logic [15:0] A_ACR       = 16'hfe1f;
  localparam logic [4:0]  SECURE_ROW  = 5'h0f;
  localparam logic [7:0]  BLANK       = 8'hff;
  // Control register fields, config security bit, divider lock bit
  localparam int CTL_PGM   = 0;
  localparam int CTL_AUTO  = 1;
  localparam int CTL_LAT   = 2;
  localparam int CTL_RAS0  = 3;
  localparam int CTL_OFF   = 5;
  localparam int CTL_SPARE = 7;
  localparam int CFG_SEC   = 4;
  localparam int DIV_LOCK  = 7;
  // Event bits in status and mask
  localparam int EV_DONE   = 0;
  localparam int EV_REFUSE = 1;
  localparam int EV_W      = 2;
  // Self-timed durations in 35 us timebase ticks
  localparam logic [7:0] PGM_TICKS   = 8'h0a;
  localparam logic [7:0] BYTE_TICKS  = 8'h0a;
  localparam logic [7:0] BLOCK_TICKS = 8'h0a;
  localparam logic [7:0] BULK_TICKS  = 8'h0a;
  typedef enum logic [1:0] {
    MODE_PROG, MODE_BYTE_ERASE, MODE_BLOCK_ERASE, MODE_BULK_ERASE
  } eepc_mode_e;
  typedef enum {ST_IDLE, ST_WALK} eepc_state_e;
endpackage

// File: eepc_tb_if.sv
// Link between the controller and its timebase divider
interface eepc_tb_if #(parameter int DIV_W = 11);
  logic             refSel;
  logic             xtalTick;
  logic [DIV_W-1:0] divisor;
  logic             tick;
  modport ctrl (output refSel, output xtalTick, output divisor, input tick);
  modport div  (input refSel, input xtalTick, input divisor, output tick);
endinterface

// File: eepc_timebase.sv
// Timebase divider producing the program and erase tick
module eepc_timebase
  import eepc_pkg::*;
#(
  parameter int DIV_W = 11
)(
  input  wire logic clk,
  input  wire logic srst,
  eepc_tb_if.div    tb
);
  initial
  begin
    if (DIV_W < 1 || DIV_W > 16)
      $error("eepc_timebase: DIV_W out of range");
  end

  logic [DIV_W-1:0] count;
  logic             tick;
  wire              refEn   = tb.refSel ? tb.xtalTick : 1'b1; // RQ3
  wire              atLimit = (count + 1'b1) == tb.divisor;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      count <= '0;
      tick  <= 1'b0;
    end
    else
    begin
      tick <= refEn && atLimit && (tb.divisor != '0); // RQ19
      if (refEn)
        count <= atLimit ? '0 : count + 1'b1; // RQ19
    end
  end

  assign tb.tick = tick;
endmodule // eepc_timebase

// File: eepc_ctrl.sv
// EEPROM array controller with register port and self-timed cycles
//
// The strobed register port and the placing of the registers are this design's own decisions.
module eepc_ctrl
  import eepc_pkg::*;
#(
  parameter int DIV_W = 11
)(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  input  wire logic        divClkSel,
  input  wire logic        xtalTick,
  output logic      [7:0]  rdata,
  output logic             irq,
  output logic             pumpOn
);
  initial
  begin
    if (DIV_W != 11)
      $error("eepc_ctrl: divider field is 11 bits");
  end

  ////////////////////////////////////////////////////////////////////////
  // Storage: array and nonvolatile registers keep contents over reset
  logic [7:0] mem [512] = '{default: BLANK}; // RQ1 RQ11
  logic [7:0] cfgNv   = BLANK;
  logic [7:0] divNvHi = BLANK;
  logic [7:0] divNvLo = BLANK;

  logic [7:0]       acr;
  logic             divLock;
  logic [DIV_W-1:0] divVal;
  logic [7:0]       ctrl;
  logic [15:0]      latAddr;
  logic [7:0]       latData;
  logic             latValid;
  logic [7:0]       tickCnt;
  logic [EV_W-1:0]  irqStat;
  logic [EV_W-1:0]  irqMask;
  eepc_state_e      state;
  logic [8:0]       walkAddr;
  logic [8:0]       walkEnd;
  logic             walkProg;

  eepc_tb_if #(.DIV_W(DIV_W)) tb ();
  assign tb.refSel   = divClkSel;
  assign tb.xtalTick = xtalTick;
  assign tb.divisor  = divVal;

  eepc_timebase #(.DIV_W(DIV_W)) u_tb (
    .clk  (clk),
    .srst (srst),
    .tb   (tb)
  );

  ////////////////////////////////////////////////////////////////////////
  // Address decode
  wire inArr   = addr >= ARR_LO && addr <= ARR_HI; // RQ1
  wire wrArr   = wr && inArr;
  wire rdArr   = rd && inArr;
  wire isNvTgt = addr == A_CFGNV || addr == A_DIVNV_HI || addr == A_DIVNV_LO;
  wire wrCtrl  = wr && addr == A_CTRL;
  wire wrDivHi = wr && addr == A_DIV_HI && divLock; // RQ10
  wire wrDivLo = wr && addr == A_DIV_LO && divLock; // RQ10
  wire rdCfgNv = rd && addr == A_CFGNV;

  wire pgmOn    = ctrl[CTL_PGM];
  wire latOn    = ctrl[CTL_LAT];
  wire autoOn   = ctrl[CTL_AUTO];
  wire [1:0] md = ctrl[CTL_RAS0+1:CTL_RAS0];
  wire armed    = !cfgNv[CFG_SEC]; // RQ5 RQ6

  ////////////////////////////////////////////////////////////////////////
  // Target checks on the latched address
  wire        latArr   = latAddr >= ARR_LO && latAddr <= ARR_HI;
  wire [8:0]  latOff   = latAddr[8:0];
  wire        latProt  = acr[latOff[8:7]]; // RQ8
  wire        latSecur = latOff[8:4] == SECURE_ROW;
  wire        byteMode = md == MODE_PROG || md == MODE_BYTE_ERASE;
  wire        tgtCfg   = latAddr == A_CFGNV;
  wire        tgtDiv   = latAddr == A_DIVNV_HI || latAddr == A_DIVNV_LO;
  wire arrOk = byteMode ? !latProt && !(armed && latSecur) // RQ5 RQ15
             : md == MODE_BLOCK_ERASE ? !armed && !latProt // RQ7 RQ8
             : !armed; // RQ7
  wire opOk  = latArr ? arrOk
             : tgtCfg ? byteMode && !armed // RQ6 RQ15
             : tgtDiv ? byteMode && divLock // RQ10
             : 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // Control write: enable rules and termination
  wire reqPgm   = wrCtrl && wdata[CTL_PGM];
  wire canPgm   = latOn && latValid && state == ST_IDLE; // RQ16
  wire setPgm   = reqPgm && !pgmOn && canPgm;
  wire refusePg = reqPgm && !pgmOn && !canPgm;
  wire [7:0] limit = md == MODE_PROG        ? PGM_TICKS
                   : md == MODE_BYTE_ERASE  ? BYTE_TICKS
                   : md == MODE_BLOCK_ERASE ? BLOCK_TICKS
                   : BULK_TICKS;
  wire autoEnd  = pgmOn && autoOn && tb.tick && (tickCnt + 8'h01) >= limit; // RQ14
  wire swEnd    = pgmOn && wrCtrl && !wdata[CTL_PGM];
  wire commit   = autoEnd || swEnd;
  wire badOp    = commit && !opOk;

  logic [7:0] next_ctrl;
  always_comb
  begin
    next_ctrl = ctrl;
    if (wrCtrl)
    begin
      next_ctrl[CTL_SPARE] = wdata[CTL_SPARE];
      next_ctrl[CTL_OFF]   = wdata[CTL_OFF];
      next_ctrl[CTL_AUTO]  = wdata[CTL_AUTO];
      if (!pgmOn)
        next_ctrl[CTL_RAS0+1:CTL_RAS0] = wdata[CTL_RAS0+1:CTL_RAS0];
      // Latch cannot drop while the pump is on
      next_ctrl[CTL_LAT] = pgmOn ? 1'b1 : wdata[CTL_LAT]; // RQ18
      next_ctrl[CTL_PGM] = pgmOn ? wdata[CTL_PGM] : setPgm; // RQ16
    end
    if (autoEnd)
      next_ctrl[CTL_PGM] = 1'b0; // RQ14
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data
  logic [7:0] next_rdata;
  always_comb
  begin
    next_rdata = 8'h00;
    if (inArr)
      next_rdata = latOn ? latData : mem[addr[8:0]];
    else
      unique case (addr)
        A_DIVNV_HI: next_rdata = divNvHi;
        A_DIVNV_LO: next_rdata = divNvLo;
        A_IRQ_STAT: next_rdata = {6'h00, irqStat};
        A_IRQ_MASK: next_rdata = {6'h00, irqMask};
        A_DIV_HI:   next_rdata = {divLock, 4'h0, divVal[10:8]};
        A_DIV_LO:   next_rdata = divVal[7:0];
        A_CFGNV:    next_rdata = cfgNv;
        A_CTRL:     next_rdata = {ctrl[7], 1'b0, ctrl[5:0]};
        A_ACR:      next_rdata = acr;
        default:    next_rdata = 8'h00;
      endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Control, configuration and latch registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ctrl     <= 8'h00;
      acr      <= cfgNv; // RQ2
      divLock  <= divNvHi[DIV_LOCK]; // RQ2 RQ10
      divVal   <= {divNvHi[2:0], divNvLo}; // RQ2
      latAddr  <= 16'h0000;
      latData  <= 8'h00;
      latValid <= 1'b0;
      tickCnt  <= 8'h00;
      rdata    <= 8'h00;
      pumpOn   <= 1'b0;
    end
    else
    begin
      ctrl   <= next_ctrl;
      rdata  <= next_rdata;
      pumpOn <= next_ctrl[CTL_PGM];
      if (wr && addr == A_ACR)
        acr[7:5] <= wdata[7:5];
      if (rdCfgNv)
        acr[3:0] <= cfgNv[3:0]; // RQ9
      if (wrDivHi)
      begin
        divLock      <= wdata[DIV_LOCK];
        divVal[10:8] <= wdata[2:0];
      end
      if (wrDivLo)
        divVal[7:0] <= wdata;
      if (latOn && !pgmOn && wr && (inArr || isNvTgt))
      begin
        latAddr  <= addr; // RQ17
        latData  <= wdata;
        latValid <= 1'b1;
      end
      else if (latOn && !pgmOn && rdArr)
        latAddr <= addr;
      if (!next_ctrl[CTL_LAT])
        latValid <= 1'b0;
      if (setPgm)
        tickCnt <= 8'h00;
      else if (pgmOn && tb.tick)
        tickCnt <= tickCnt + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Array update: byte ops walk one address, block and bulk walk many
  wire [8:0] lo = md == MODE_BULK_ERASE  ? 9'h000
                : md == MODE_BLOCK_ERASE ? {latOff[8:7], 7'h00}
                : latOff;
  wire [8:0] hi = md == MODE_BULK_ERASE  ? 9'h1ff
                : md == MODE_BLOCK_ERASE ? {latOff[8:7], 7'h7f}
                : latOff;
  wire walkOk = !acr[walkAddr[8:7]]; // RQ8

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state    <= ST_IDLE;
      walkAddr <= 9'h000;
      walkEnd  <= 9'h000;
      walkProg <= 1'b0;
    end
    else
    begin
      unique case (state)
        ST_IDLE:
        begin
          if (commit && opOk && latArr)
          begin
            state    <= ST_WALK;
            walkAddr <= lo;
            walkEnd  <= hi;
            walkProg <= md == MODE_PROG;
          end
        end
        ST_WALK:
        begin
          walkAddr <= walkAddr + 9'h001;
          if (walkAddr == walkEnd)
            state <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (state == ST_WALK && walkOk)
      mem[walkAddr] <= walkProg ? mem[walkAddr] & latData : BLANK; // RQ11 RQ12
    if (commit && opOk && !latArr)
    begin
      if (tgtCfg)
        cfgNv <= md == MODE_PROG ? cfgNv & latData : BLANK; // RQ11
      if (latAddr == A_DIVNV_HI)
        divNvHi <= md == MODE_PROG ? divNvHi & latData : BLANK;
      if (latAddr == A_DIVNV_LO)
        divNvLo <= md == MODE_PROG ? divNvLo & latData : BLANK;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt status, write one to clear, set wins
  wire [EV_W-1:0] evSet = {refusePg || badOp, commit && opOk};
  wire [EV_W-1:0] evClr = (wr && addr == A_IRQ_STAT) ? wdata[EV_W-1:0] : '0;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      irqStat <= '0;
      irqMask <= '0;
      irq     <= 1'b0;
    end
    else
    begin
      irqStat <= (irqStat & ~evClr) | evSet;
      if (wr && addr == A_IRQ_MASK)
        irqMask <= wdata[EV_W-1:0];
      irq <= |(((irqStat & ~evClr) | evSet) & irqMask);
    end
  end
endmodule // eepc_ctrl

// File: eepc_ctrl_sva.sv
// Port-level assertions of the EEPROM controller
module eepc_ctrl_sva
  import eepc_pkg::*;
(
  input wire logic        clk,
  input wire logic        srst,
  input wire logic [15:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [7:0]  rdata,
  input wire logic        irq,
  input wire logic        pumpOn
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic maskOff;
  logic autoOn;
  wire  ctlWr = wr && addr == A_CTRL;
  wire  mskWr = wr && addr == A_IRQ_MASK;
  ////////////////////////////////////////
  always_ff @(posedge clk)
  begin
    maskOff <= srst ? 1'b0 : (mskWr ? wdata[1:0] == 2'h0 : maskOff);
    autoOn  <= srst ? 1'b0 : (ctlWr ? wdata[CTL_AUTO] : autoOn);
  end
  a_rst_quiet: assert property (disable iff (1'b0) srst |=>
    rdata == 8'h00 && !irq && !pumpOn) else $error("reset state wrong");
  a_pump_cause: assert property ($rose(pumpOn) |->
    $past(ctlWr && wdata[CTL_PGM])) else $error("pump on without enable write");
  a_pump_stays: assert property (pumpOn && !autoOn && !ctlWr |=> pumpOn)
    else $error("pump dropped without cause");
  a_unmapped_zero: assert property (rd && addr > ARR_HI && addr < A_DIVNV_HI
    |=> rdata == 8'h00) else $error("unmapped read not zero");
  a_ctrl_bit6: assert property (rd && addr == A_CTRL |=> !rdata[6])
    else $error("control bit 6 set");
  a_divhi_zero: assert property (rd && addr == A_DIV_HI |=> rdata[6:3] == 4'h0)
    else $error("divider high reserved bits set");
  a_irq_masked: assert property (maskOff |=> !irq) else $error("masked irq raised");
  a_ctrl_readback: assert property (ctlWr && !pumpOn ##1 !wr ##1 (rd && addr == A_CTRL)
    |=> rdata[7:3] == {$past(wdata[7], 3), 1'b0, $past(wdata[5:3], 3)})
    else $error("control readback wrong");
  c_auto: cover property ($rose(pumpOn) && autoOn ##[1:200] !pumpOn);
  c_irq: cover property ($rose(irq));
  c_manual: cover property (pumpOn && !autoOn ##1 ctlWr ##1 !pumpOn);
endmodule // eepc_ctrl_sva

bind eepc_ctrl eepc_ctrl_sva u_eepc_ctrl_sva (.clk(clk), .srst(srst), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .pumpOn(pumpOn));

// File: eepc_ctrl_tb.sv
// Self-checking bench of the EEPROM program and erase controller
module eepc_ctrl_tb
  import eepc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        divClkSel = 1'b0;
  logic        xtalTick = 1'b0;
  logic [7:0]  rdata;
  logic        irq;
  logic        pumpOn;
  int          err_total = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          i;
  always #25 clk = ~clk;
  always @(posedge clk) xtalTick <= ~xtalTick;
  eepc_ctrl u_eepc_ctrl (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .divClkSel(divClkSel), .xtalTick(xtalTick), .rdata(rdata), .irq(irq),
    .pumpOn(pumpOn));
  ////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrReg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rdChk(input string nm, input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(nm, e, rdata);
  endtask
  task automatic stat(input logic [7:0] e);
    rdChk("status", A_IRQ_STAT, e);
    wrReg(A_IRQ_STAT, 8'h03);
  endtask
  // Latch, load, pump on, end by software, unlatch, let any walk finish
  task automatic op(input logic [7:0] m, input logic [15:0] a, input logic [7:0] d);
    wrReg(A_CTRL, m);
    wrReg(a, d);
    wrReg(A_CTRL, m | 8'h01);
    wrReg(A_CTRL, m);
    wrReg(A_CTRL, 8'h00);
    repeat (520) @(posedge clk);
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    rdChk("shadow", A_ACR, 8'hff);
    rdChk("div high", A_DIV_HI, 8'h87);
    rdChk("div low", A_DIV_LO, 8'hff);
    rdChk("control", A_CTRL, 8'h00);
    rdChk("array top", ARR_HI, BLANK);
    rdChk("unmapped", 16'h0a00, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_refuse();
    wrReg(A_IRQ_MASK, 8'h02);
    wrReg(A_CTRL, 8'h01);
    rdChk("control", A_CTRL, 8'h00);
    rdChk("status", A_IRQ_STAT, 8'h02);
    chk("irq", 8'h01, {7'h00, irq});
    stat(8'h02);
    chk("irq", 8'h00, {7'h00, irq});
    wrReg(A_IRQ_MASK, 8'h00);
    op(8'h04, 16'h0900, 8'h00);
    rdChk("protected", 16'h0900, BLANK);
    stat(8'h02);
    $display("test refuse done");
  endtask
  task automatic t_div();
    wrReg(A_DIV_LO, 8'h04);
    wrReg(A_DIV_HI, 8'h80);
    rdChk("div high", A_DIV_HI, 8'h80);
    wrReg(A_DIV_HI, 8'h00);
    wrReg(A_DIV_LO, 8'h09);
    rdChk("div low", A_DIV_LO, 8'h04);
    op(8'h04, A_DIVNV_LO, 8'h00);
    rdChk("div nv low", A_DIVNV_LO, 8'hff);
    $display("test divider done");
  endtask
  task automatic t_cfg();
    stat(8'h02);
    op(8'h04, A_CFGNV, 8'hf0);
    stat(8'h01);
    op(8'h04, ARR_LO, 8'h00);
    rdChk("stale", ARR_LO, BLANK);
    rdChk("cfg nv", A_CFGNV, 8'hf0);
    rdChk("shadow", A_ACR, 8'hf0);
    $display("test config done");
  endtask
  task automatic t_prog();
    wrReg(A_CTRL, 8'h04);
    wrReg(16'h0806, 8'haa);
    wrReg(16'h0805, 8'hf5);
    wrReg(A_CTRL, 8'h05);
    chk("pump", 8'h01, {7'h00, pumpOn});
    wrReg(A_CTRL, 8'h00);
    rdChk("control", A_CTRL, 8'h04);
    wrReg(A_CTRL, 8'h00);
    rdChk("last", 16'h0805, 8'hf5);
    rdChk("replaced", 16'h0806, BLANK);
    op(8'h04, 16'h0805, 8'h7e);
    rdChk("and", 16'h0805, 8'h74);
    $display("test program done");
  endtask
  task automatic t_erase();
    op(8'h0c, 16'h0805, 8'h00);
    rdChk("byte", 16'h0805, BLANK);
    op(8'h04, 16'h0900, 8'h00);
    op(8'h04, 16'h0980, 8'h00);
    op(8'h14, 16'h0905, 8'h00);
    rdChk("block", 16'h0900, BLANK);
    rdChk("other block", 16'h0980, 8'h00);
    op(8'h1c, ARR_LO, 8'h00);
    rdChk("bulk", 16'h0980, BLANK);
    $display("test erase done");
  endtask
  task automatic t_auto();
    divClkSel <= 1'b1;
    wrReg(A_CTRL, 8'h06);
    wrReg(16'h0820, 8'h0f);
    wrReg(A_CTRL, 8'h07);
    for (i = 0; i < 300 && pumpOn; i++)
      @(posedge clk);
    chk("auto span", 8'h01, {7'h00, i >= 70 && i <= 100});
    rdChk("control", A_CTRL, 8'h06);
    wrReg(A_CTRL, 8'h00);
    rdChk("auto byte", 16'h0820, 8'h0f);
    $display("test auto done");
  endtask
  task automatic t_secure();
    op(8'h04, A_CFGNV, 8'he0);
    op(8'h04, 16'h08f5, 8'h00);
    rdChk("secured", 16'h08f5, BLANK);
    op(8'h0c, A_CFGNV, 8'h00);
    rdChk("cfg nv", A_CFGNV, 8'he0);
    op(8'h04, 16'h0900, 8'h00);
    op(8'h14, 16'h0900, 8'h00);
    rdChk("no block", 16'h0900, 8'h00);
    op(8'h0c, 16'h0900, 8'h00);
    rdChk("byte ok", 16'h0900, BLANK);
    $display("test secure done");
  endtask
  ////////////////////////////////////////
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      err_total++;
      end_sim();
    end
  end
  initial
  begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_refuse();
    t_div();
    t_cfg();
    t_prog();
    t_erase();
    t_auto();
    t_secure();
    end_sim();
  end
endmodule // eepc_ctrl_tb
